// file: design/osc_pkg.sv
// What this block does
// - Frames are sixteen bits per device
// - Daisy chain: shift through, mixed 8-bit devices
// - Serial access works only with digital supply
// - Each input pin drives one channel after reset
// - Programmed mapping lets pins drive any channels
// - Limp-home routes pins to channels 2, 3
// - Idle low: pins switch limp channels in limp-home or without supply
// - Overload latches channel off until reactivation
// - Limp-home overload retries after restart time
// - Over-temperature switches channel off, latched
// - Serial command enables open-load test current
// - Output status monitor and pin levels reported
// - Faults stay latched, readable over serial
// - Chip select low active; output floats otherwise
// - Low-power pin high selects idle mode
// - Default: pin 0 to ch 2, pin 1 to ch 3
package osc_pkg;
  // ----------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------
  localparam int NCH = 8;
  localparam int FRAME_BITS = 16;
  localparam int CNT_W = 5;
  localparam int RETRY_W = 20;
  // ----------------------------------------------------------
  // Timing
  // ----------------------------------------------------------
  localparam int MCLK_FREQ_MHZ = 125;
  localparam int SCLK_MAX_KHZ = 5000;
  localparam int LH_RETRY_TIME_US = 1000;
  localparam int LH_RETRY_CYC = LH_RETRY_TIME_US * MCLK_FREQ_MHZ;
  // ----------------------------------------------------------
  // Reset values and limp-home channels
  // ----------------------------------------------------------
  localparam int LH_CH_IN0 = 2;
  localparam int LH_CH_IN1 = 3;
  localparam logic [7:0] MAP0_RST = 8'h04;
  localparam logic [7:0] MAP1_RST = 8'h08;
  localparam logic [7:0] LIMP_MASK = 8'h0c;
  // ----------------------------------------------------------
  // Frame fields
  // ----------------------------------------------------------
  localparam int CMD_LO = 14;
  localparam int SUB_LO = 8;
  localparam int MAP_SEL_BIT = 8;
  // ----------------------------------------------------------
  // Synchroniser bit positions
  // ----------------------------------------------------------
  localparam int SY_SCLK = 0;
  localparam int SY_CSN = 1;
  localparam int SY_SI = 2;
  localparam int SY_VDD = 3;
  localparam int SY_IDLE = 4;
  localparam int SY_IN0 = 5;
  localparam int SY_IN1 = 6;
  localparam int SY_LIMP = 7;
  localparam int SY_OVL = 8;
  localparam int SY_OT = 16;
  localparam int SY_OSM = 24;
  localparam int SYNC_W = 32;
  // ----------------------------------------------------------
  // Commands
  // ----------------------------------------------------------
  typedef enum logic [1:0] {
    OSC_CMD_READ = 2'b00,
    OSC_CMD_OUT = 2'b01,
    OSC_CMD_MAP = 2'b10,
    OSC_CMD_SPEC = 2'b11
  } osc_cmd_e;
  typedef enum logic [1:0] {
    OSC_SUB_REACT = 2'b00,
    OSC_SUB_OLSRC = 2'b01,
    OSC_SUB_CLRDIAG = 2'b10,
    OSC_SUB_RSVD = 2'b11
  } osc_sub_e;
  typedef enum logic [1:0] {
    OSC_RD_DIAG = 2'b00,
    OSC_RD_OSM = 2'b01,
    OSC_RD_LATCH = 2'b10,
    OSC_RD_OUT = 2'b11
  } osc_rd_e;
endpackage

// file: design/osc_sync.sv
`timescale 1ns/1ps
// Two-flop synchroniser bank for all asynchronous pins
module osc_sync #(
  parameter int W = 8
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // Data
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } osc_sync_s;

  osc_sync_s r;
  osc_sync_s r_nxt;

  // First stage feeds only the second
  always_comb
  begin
    r_nxt.s1 = i_async;
    r_nxt.s2 = r.s1;
  end

  // Pins float low at reset, matching pull-downs
  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
      r <= '0;
    else
      r <= r_nxt;
  end

  assign o_sync = r.s2;
endmodule // osc_sync

// file: design/osc_core.sv
`timescale 1ns/1ps
// Eight-channel switch control: serial port, mapping, protection
module osc_core #(
  parameter int P_RETRY_CYC = osc_pkg::LH_RETRY_CYC
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // Serial port pins
  input wire logic i_sclk,
  input wire logic i_csn,
  input wire logic i_si,
  output logic o_so,
  output logic o_so_oe,
  // Supply and mode pins
  input wire logic i_vdd_ok,
  input wire logic i_idle,
  input wire logic i_limp_home,
  // Parallel inputs
  input wire logic i_parallel_input_0,
  input wire logic i_parallel_input_1,
  // Per-channel sensing
  input wire logic [7:0] i_overload,
  input wire logic [7:0] i_overtemp,
  input wire logic [7:0] i_out_level,
  // Channel drive and status
  output logic [7:0] o_chan_on,
  output logic [7:0] o_ol_src_en,
  output logic [7:0] o_fault_latched,
  output logic o_idle_mode
);
  localparam int RW = osc_pkg::RETRY_W;
  localparam logic [RW-1:0] RETRY_LAST = RW'(P_RETRY_CYC - 1);
  localparam logic [4:0] FRAME_CNT = 5'(osc_pkg::FRAME_BITS);

  typedef struct packed {
    logic sclk_d;
    logic csn_d;
    logic [15:0] sh;
    logic [4:0] bits;
    logic so;
    logic so_oe;
    logic [1:0] rd_sel;
    logic [7:0] out_ctl;
    logic [7:0] map0;
    logic [7:0] map1;
    logic [7:0] ol_en;
    logic [7:0] ovl_lat;
    logic [7:0] ot_lat;
    logic [7:0] diag;
    logic [7:0][RW-1:0] retry;
    logic [7:0] chan_on;
    logic idle;
  } osc_core_s;

  osc_core_s r;
  osc_core_s r_nxt;
  logic [osc_pkg::SYNC_W-1:0] sy;
  logic sclk_s, csn_s, si_s, vdd_s, idle_s, in0_s, in1_s, limp_s;
  logic [7:0] ovl_s, ot_s, osm_s;
  logic exec;
  logic [1:0] cmd;
  logic [1:0] sub;
  logic [7:0] rsp_data;

  // ----------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------
  osc_sync #(
    .W(osc_pkg::SYNC_W)
  ) u_sync (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_async({i_out_level, i_overtemp, i_overload, i_limp_home,
      i_parallel_input_1, i_parallel_input_0, i_idle, i_vdd_ok,
      i_si, i_csn, i_sclk}),
    .o_sync(sy)
  );

  // Unpack synchronised pins
  assign sclk_s = sy[osc_pkg::SY_SCLK];
  assign csn_s = sy[osc_pkg::SY_CSN];
  assign si_s = sy[osc_pkg::SY_SI];
  assign vdd_s = sy[osc_pkg::SY_VDD];
  assign idle_s = sy[osc_pkg::SY_IDLE];
  assign in0_s = sy[osc_pkg::SY_IN0];
  assign in1_s = sy[osc_pkg::SY_IN1];
  assign limp_s = sy[osc_pkg::SY_LIMP];
  assign ovl_s = sy[osc_pkg::SY_OVL +: 8];
  assign ot_s = sy[osc_pkg::SY_OT +: 8];
  assign osm_s = sy[osc_pkg::SY_OSM +: 8];

  // ----------------------------------------------------------
  // Frame decode
  // ----------------------------------------------------------
  // Last sixteen bits in the chain belong to us
  assign exec = csn_s && !r.csn_d && vdd_s && (r.bits == FRAME_CNT);
  assign cmd = r.sh[osc_pkg::CMD_LO +: 2];
  assign sub = r.sh[osc_pkg::SUB_LO +: 2];

  // Reply payload chosen by the previous read command
  always_comb
  begin
    unique case (osc_pkg::osc_rd_e'(r.rd_sel))
      osc_pkg::OSC_RD_DIAG: rsp_data = r.diag;
      osc_pkg::OSC_RD_OSM: rsp_data = osm_s;
      osc_pkg::OSC_RD_LATCH: rsp_data = r.ovl_lat | r.ot_lat;
      osc_pkg::OSC_RD_OUT: rsp_data = r.out_ctl;
    endcase
  end

  // ----------------------------------------------------------
  // Next state
  // ----------------------------------------------------------
  always_comb
  begin
    logic lh_in;
    logic map_in;
    logic req;
    logic [7:0] react;
    logic [7:0] clr;
    lh_in = 1'b0;
    map_in = 1'b0;
    req = 1'b0;
    react = '0;
    clr = '0;
    r_nxt = r;
    r_nxt.sclk_d = sclk_s;
    r_nxt.csn_d = csn_s;
    r_nxt.idle = idle_s;
    // Output floats whenever chip select is high
    r_nxt.so_oe = !csn_s && vdd_s;
    // Serial shift; bits beyond sixteen pass downstream
    if (!csn_s && r.csn_d)
    begin
      r_nxt.sh = {r.rd_sel, 4'h0, in1_s, in0_s, rsp_data};
      r_nxt.bits = '0;
      r_nxt.so = r.rd_sel[1];
    end
    else if (!csn_s && sclk_s && !r.sclk_d)
    begin
      r_nxt.sh = {r.sh[14:0], si_s};
      if (r.bits != FRAME_CNT)
        r_nxt.bits = r.bits + 5'h01;
    end
    else if (!csn_s && !sclk_s && r.sclk_d)
      r_nxt.so = r.sh[15];
    // Commands take effect on chip select release
    if (exec)
    begin
      unique case (osc_pkg::osc_cmd_e'(cmd))
        osc_pkg::OSC_CMD_READ: r_nxt.rd_sel = r.sh[1:0];
        osc_pkg::OSC_CMD_OUT: r_nxt.out_ctl = r.sh[7:0];
        osc_pkg::OSC_CMD_MAP:
        begin
          if (r.sh[osc_pkg::MAP_SEL_BIT])
            r_nxt.map1 = r.sh[7:0];
          else
            r_nxt.map0 = r.sh[7:0];
        end
        osc_pkg::OSC_CMD_SPEC:
        begin
          unique case (osc_pkg::osc_sub_e'(sub))
            osc_pkg::OSC_SUB_REACT: react = r.sh[7:0];
            osc_pkg::OSC_SUB_OLSRC: r_nxt.ol_en = r.sh[7:0];
            osc_pkg::OSC_SUB_CLRDIAG: clr = r.sh[7:0];
            osc_pkg::OSC_SUB_RSVD: r_nxt.ol_en = r.ol_en;
          endcase
        end
      endcase
    end
    // Without supply the configuration falls back to defaults
    if (!vdd_s)
    begin
      r_nxt.out_ctl = '0;
      r_nxt.map0 = osc_pkg::MAP0_RST;
      r_nxt.map1 = osc_pkg::MAP1_RST;
      r_nxt.ol_en = '0;
      r_nxt.rd_sel = '0;
    end
    // Per-channel protection and drive
    for (int ch = 0; ch < osc_pkg::NCH; ch++)
    begin
      lh_in = (ch == osc_pkg::LH_CH_IN0 && in0_s) ||
        (ch == osc_pkg::LH_CH_IN1 && in1_s);
      map_in = (r.map0[ch] && in0_s) || (r.map1[ch] && in1_s);
      // Set needs the channel on, so a fault in the clearing cycle latches again one cycle after the channel turns back on
      r_nxt.ovl_lat[ch] = (r.ovl_lat[ch] && !react[ch]) ||
        (r.chan_on[ch] && ovl_s[ch]);
      r_nxt.ot_lat[ch] = (r.ot_lat[ch] && !react[ch]) ||
        (r.chan_on[ch] && ot_s[ch]);
      r_nxt.diag[ch] = (r.diag[ch] && !clr[ch]) ||
        (r.chan_on[ch] && (ovl_s[ch] || ot_s[ch]));
      // Limp-home auto restart for overload only
      if (limp_s && lh_in && r.ovl_lat[ch] && !ovl_s[ch])
      begin
        if (r.retry[ch] == RETRY_LAST)
        begin
          r_nxt.ovl_lat[ch] = 1'b0;
          r_nxt.retry[ch] = '0;
        end
        else
          r_nxt.retry[ch] = r.retry[ch] + RW'(1);
      end
      else
        r_nxt.retry[ch] = '0;
      // Idle overrides, limp bypasses mapping, else map or serial
      if (idle_s)
        req = 1'b0;
      else if (limp_s)
        req = lh_in;
      else
        req = map_in || (vdd_s && r.out_ctl[ch]);
      r_nxt.chan_on[ch] = req && !r_nxt.ovl_lat[ch] && !r_nxt.ot_lat[ch];
    end
  end

  // ----------------------------------------------------------
  // State register
  // ----------------------------------------------------------
  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      r <= '0;
      // Sync flops clear low, so chip select history starts low too
      r.map0 <= osc_pkg::MAP0_RST;
      r.map1 <= osc_pkg::MAP1_RST;
    end
    else
      r <= r_nxt;
  end

  // Outputs from flops; only the test current enable is gated
  assign o_so = r.so;
  assign o_so_oe = r.so_oe;
  assign o_chan_on = r.chan_on;
  // Test current only meaningful while the switch is off
  assign o_ol_src_en = r.ol_en & ~r.chan_on;
  assign o_fault_latched = r.diag;
  assign o_idle_mode = r.idle;

  // ----------------------------------------------------------
  // Checks
  // ----------------------------------------------------------
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_rst);

  chk_so_float: assert property (csn_s |=> !o_so_oe)
    else $error("serial output driven with chip select high");
  chk_frame_cap: assert property (r.bits <= FRAME_CNT)
    else $error("bit counter ran past a frame");
  chk_nosupply_cfg: assert property (!vdd_s |=>
    (r.out_ctl == 8'h00 && r.map0 == osc_pkg::MAP0_RST))
    else $error("configuration kept without digital supply");
  chk_idle_off: assert property (idle_s |=> o_chan_on == 8'h00)
    else $error("channel on in idle mode");
  chk_limp_only: assert property ((limp_s && !idle_s)
    |=> (o_chan_on & ~osc_pkg::LIMP_MASK) == 8'h00)
    else $error("non limp channel on in limp-home");
  chk_limp_in0: assert property ((limp_s && !idle_s && in0_s &&
    !r_nxt.ovl_lat[2] && !r_nxt.ot_lat[2]) |=> o_chan_on[2])
    else $error("limp channel 2 not following pin 0");
  chk_map_follow: assert property ((!limp_s && !idle_s && r.map0[5] &&
    in0_s && !r_nxt.ovl_lat[5] && !r_nxt.ot_lat[5])
    |=> o_chan_on[5])
    else $error("mapped channel not following pin 0");
  chk_ovl_off: assert property ((o_chan_on[0] && ovl_s[0])
    |=> !o_chan_on[0] && r.ovl_lat[0])
    else $error("overload did not latch channel off");
  chk_ot_off: assert property ((o_chan_on[1] && ot_s[1])
    |=> !o_chan_on[1] && r.ot_lat[1])
    else $error("over-temperature did not latch off");
  chk_latch_hold: assert property ((r.ovl_lat[0] && !exec)
    |=> r.ovl_lat[0])
    else $error("overload latch cleared without command");
  chk_diag_sticky: assert property ((r.diag[4] && !exec)
    |=> r.diag[4])
    else $error("diagnostic bit lost without clear");
  chk_lh_retry: assert property ((limp_s && in0_s && r.ovl_lat[2] &&
    !ovl_s[2] && r.retry[2] == RETRY_LAST) |=> !r.ovl_lat[2])
    else $error("limp-home restart missed");

  cov_exec: cover property (exec && cmd == 2'b11);
  cov_retry: cover property (r.ovl_lat[2] ##1 !r.ovl_lat[2] && limp_s);
  cov_limp_on: cover property (limp_s && o_chan_on[3]);
  cov_diag: cover property (!r.diag[6] ##1 r.diag[6]);
endmodule // osc_core

// file: tb/osc_host_model.sv
`timescale 1ns/1ps
// --------------------------------------------------------
// Host serial master model
// --------------------------------------------------------
module osc_host_model #(
  parameter real P_HALF_NS = 100.0
) (
  // Serial pins
  output logic o_sclk,
  output logic o_csn,
  output logic o_si,
  input wire logic i_so
);
  // Idle levels follow the pin pulls, clock stands still
  initial
  begin
    o_sclk = 1'b0;
    o_csn = 1'b1;
    o_si = 1'b0;
  end

  // One frame, MSB first; extra bits shift through a chain
  task automatic xfer(input logic [31:0] tx, input int nb,
    output logic [31:0] rx);
    rx = '0;
    o_csn = 1'b0;
    for (int i = nb - 1; i >= 0; i--)
    begin
      o_si = tx[i];
      #(P_HALF_NS);
      o_sclk = 1'b1;
      rx[i] = i_so;
      #(P_HALF_NS);
      o_sclk = 1'b0;
    end
    #(P_HALF_NS);
    o_csn = 1'b1;
    o_si = 1'b0;
    #(2.0 * P_HALF_NS);
  endtask
endmodule // osc_host_model

// file: tb/test_octal_switch_channel_control.sv
`timescale 1ns/1ps
// --------------------------------------------------------
// Bench for the octal switch channel control
// --------------------------------------------------------
module test_octal_switch_channel_control;
  logic i_mclk = 1'b0;
  logic i_rst, i_sclk, i_csn, i_si, i_vdd_ok, i_idle, i_limp_home;
  logic i_parallel_input_0, i_parallel_input_1;
  logic [7:0] i_overload, i_overtemp, i_out_level;
  logic o_so, o_so_oe, o_idle_mode;
  logic [7:0] o_chan_on, o_ol_src_en, o_fault_latched;
  logic [31:0] rx;
  wire so_w;
  int err_total = 0;
  int n_compared = 0;

  // Released output floats, so a late read never looks valid
  assign so_w = o_so_oe ? o_so : 1'bz;
  // 125 MHz clock
  always #4 i_mclk = ~i_mclk;

  osc_core #(.P_RETRY_CYC(20)) u_osc_core (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_sclk(i_sclk),
    .i_csn(i_csn),
    .i_si(i_si),
    .o_so(o_so),
    .o_so_oe(o_so_oe),
    .i_vdd_ok(i_vdd_ok),
    .i_idle(i_idle),
    .i_limp_home(i_limp_home),
    .i_parallel_input_0(i_parallel_input_0),
    .i_parallel_input_1(i_parallel_input_1),
    .i_overload(i_overload),
    .i_overtemp(i_overtemp),
    .i_out_level(i_out_level),
    .o_chan_on(o_chan_on),
    .o_ol_src_en(o_ol_src_en),
    .o_fault_latched(o_fault_latched),
    .o_idle_mode(o_idle_mode)
  );

  // Link clock 125 ns, phase unrelated to the core clock
  osc_host_model #(.P_HALF_NS(62.5)) u_osc_host_model (
    .o_sclk(i_sclk),
    .o_csn(i_csn),
    .o_si(i_si),
    .i_so(so_w)
  );

  // --------------------------------------------------------
  // Checks and access tasks
  // --------------------------------------------------------
  task automatic chk_port(input string nm, input logic [7:0] exp,
    input logic [7:0] got);
    n_compared++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic chk_reply(input string nm, input logic [15:0] exp,
    input logic [15:0] got);
    n_compared++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wrap_up();
    $display("Compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(posedge i_mclk);
  endtask

  // Pin changes need two sync flops plus a register to show
  task automatic pins(input logic p0, input logic p1);
    @(posedge i_mclk);
    i_parallel_input_0 <= p0;
    i_parallel_input_1 <= p1;
    wait_n(8);
  endtask

  task automatic mode(input logic vdd, input logic idle,
    input logic limp);
    @(posedge i_mclk);
    i_vdd_ok <= vdd;
    i_idle <= idle;
    i_limp_home <= limp;
    wait_n(8);
  endtask

  // Short fault pulse, gone again before the check
  task automatic fault(input logic [7:0] ovl, input logic [7:0] ot);
    @(posedge i_mclk);
    i_overload <= ovl;
    i_overtemp <= ot;
    wait_n(6);
    i_overload <= 8'h00;
    i_overtemp <= 8'h00;
    wait_n(6);
  endtask

  task automatic q(input logic [15:0] cmd);
    u_osc_host_model.xfer({16'h0000, cmd}, 16, rx);
    wait_n(2);
  endtask

  // --------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------
  initial
  begin
    i_rst = 1'b1;
    i_vdd_ok = 1'b0;
    i_idle = 1'b0;
    i_limp_home = 1'b0;
    i_parallel_input_0 = 1'b0;
    i_parallel_input_1 = 1'b0;
    i_overload = 8'h00;
    i_overtemp = 8'h00;
    i_out_level = 8'h00;
    repeat (5) @(posedge i_mclk);
    i_rst <= 1'b0;
    wait_n(4);
    chk_port("fault", 8'h00, o_fault_latched);
    pins(1'b1, 1'b0);
    chk_port("chan_on", 8'h04, o_chan_on);
    pins(1'b1, 1'b1);
    chk_port("chan_on", 8'h0c, o_chan_on);
    q(16'h80f0);
    chk_port("chan_on", 8'h0c, o_chan_on);
    mode(1'b1, 1'b0, 1'b0);
    pins(1'b0, 1'b0);
    q(16'h4040);
    chk_port("chan_on", 8'h40, o_chan_on);
    // Short frame would turn into an out write if it were taken
    q(16'h0003);
    u_osc_host_model.xfer(32'h0000_00ff, 8, rx);
    wait_n(2);
    chk_port("chan_on", 8'h40, o_chan_on);
    q(16'h4000);
    q(16'h8031);
    q(16'h81c0);
    pins(1'b1, 1'b0);
    chk_port("chan_on", 8'h31, o_chan_on);
    pins(1'b1, 1'b1);
    chk_port("chan_on", 8'hf1, o_chan_on);
    mode(1'b1, 1'b0, 1'b1);
    chk_port("chan_on", 8'h0c, o_chan_on);
    pins(1'b0, 1'b1);
    chk_port("chan_on", 8'h08, o_chan_on);
    mode(1'b0, 1'b0, 1'b1);
    pins(1'b1, 1'b0);
    chk_port("chan_on", 8'h04, o_chan_on);
    // Limp-home overload: off, held, then restarts by itself
    @(posedge i_mclk);
    i_overload <= 8'h04;
    wait_n(6);
    chk_port("chan_on", 8'h00, o_chan_on);
    i_overload <= 8'h00;
    wait_n(10);
    chk_port("chan_on", 8'h00, o_chan_on);
    for (int k = 0; k < 40 && o_chan_on[2] !== 1'b1; k++)
      wait_n(1);
    chk_port("chan_on", 8'h04, o_chan_on);
    if (o_chan_on[2] !== 1'b1)
      wrap_up();
    mode(1'b0, 1'b1, 1'b1);
    chk_port("chan_on", 8'h00, o_chan_on);
    chk_port("idle", 8'h01, {7'h00, o_idle_mode});
    mode(1'b1, 1'b0, 1'b0);
    pins(1'b0, 1'b0);
    // Limp-home overload left its diagnostic bit behind
    chk_port("fault", 8'h04, o_fault_latched);
    q(16'hc204);
    chk_port("fault", 8'h00, o_fault_latched);
    // Latched faults survive reads, cleared only on command
    q(16'h4003);
    fault(8'h01, 8'h00);
    chk_port("chan_on", 8'h02, o_chan_on);
    chk_port("fault", 8'h01, o_fault_latched);
    fault(8'h00, 8'h02);
    chk_port("chan_on", 8'h00, o_chan_on);
    q(16'h0000);
    q(16'h0002);
    chk_reply("diag", 16'h0003, rx[15:0]);
    q(16'h0001);
    chk_reply("latched", 16'h8003, rx[15:0]);
    chk_port("chan_on", 8'h00, o_chan_on);
    q(16'hc001);
    chk_port("chan_on", 8'h01, o_chan_on);
    q(16'hc003);
    chk_port("chan_on", 8'h03, o_chan_on);
    chk_port("fault", 8'h03, o_fault_latched);
    q(16'hc203);
    chk_port("fault", 8'h00, o_fault_latched);
    @(posedge i_mclk);
    i_out_level <= 8'ha5;
    pins(1'b1, 1'b0);
    q(16'h0003);
    chk_reply("osm", 16'h41a5, rx[15:0]);
    q(16'hc1ff);
    chk_reply("out_ctl", 16'hc103, rx[15:0]);
    chk_port("ol_src", 8'hf8, o_ol_src_en);
    u_osc_host_model.xfer(32'h00a5_4010, 24, rx);
    wait_n(2);
    chk_reply("chain", 16'h00a5, {8'h00, rx[7:0]});
    chk_port("chan_on", 8'h14, o_chan_on);
    chk_port("so_oe", 8'h00, {7'h00, o_so_oe});
    wrap_up();
  end

  // Hang guard
  initial
  begin
    #400000;
    err_total++;
    $display("ERROR watchdog expected done seen hang");
    wrap_up();
  end
endmodule // test_octal_switch_channel_control
